// *** src/fbp_port.sv ***
// Five-pin bidirectional port with APB register access
//
// Function
// - Five pins, each with latch and direction
// - Latch bits writable by software, readable only on output pins
// - Reset leaves the output latch unchanged
// - Direction one drives pin, zero floats
// - Direction bits read back as written
// - Reset clears every direction bit
// - Output pin reads back its latch
// - Input pin reads back synchronised level
// - Latch writes accepted in any direction unless pstrb[0] is low
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// Register map, one aligned word each
//   DATA_ADDR  write: output latch; read: latch or pin, per direction
//   DIR_ADDR   direction bits, one per pin, 1 drives the pin
//   Live bits sit in [4:0]; [31:5] read zero and are dropped on write
//   Any other address answers with pslverr and changes nothing
//
// Bus timing
//   Setup edge: address decoded, read data captured from the live view
//   Access cycle: pready high for exactly one cycle, no wait states
//   Access edge: a write lands; pstrb[0] low drops it without an error
//   Next cycle: pready, pslverr and prdata fall back to zero
//
// Pin timing
//   pin_oe and pin_out move together, on the same edge that the write lands
//   A pin level reaches a read after two synchroniser edges, so a read
//   captured right after a change still shows the old level
//   Undriven pins put zero on pin_out, so nothing unknown leaves the block
//
// Reset
//   Direction bits clear and every pin floats as an input
//   The latch has no reset; it powers up unknown until first written,
//   which is why software loads it before raising any direction bit
//   Reads of input pins show zero for two edges after release
////////////////////////////////////////////////////////////////////////
module fbp_port (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [fbp_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [fbp_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [fbp_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [fbp_pkg::PINS-1:0]     pin_in,
  output logic      [fbp_pkg::PINS-1:0]     pin_out,
  output logic      [fbp_pkg::PINS-1:0]     pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  fbp_pkg::fbp_regs_s        cur;
  fbp_pkg::fbp_regs_s        next_cur;
  fbp_pkg::fbp_keep_s        keep;
  fbp_pkg::fbp_keep_s        next_keep;
  fbp_pkg::fbp_hit_e         hit;
  logic                      setup;
  logic                      take;
  logic                      wr_data;
  logic                      wr_dir;
  logic [fbp_pkg::PINS-1:0]  port_view;

  fbp_sync_if sif ();

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  // Pins come from outside the clock domain, so they settle first
  assign sif.raw = pin_in;

  fbp_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Only exact word addresses hit; anything else is unmapped
  always_comb begin
    if (paddr == fbp_pkg::DATA_ADDR) begin
      hit = fbp_pkg::FBP_HIT_DATA;
    end else if (paddr == fbp_pkg::DIR_ADDR) begin
      hit = fbp_pkg::FBP_HIT_DIR;
    end else begin
      hit = fbp_pkg::FBP_HIT_NONE;
    end
  end

  // Phases; pready is high only in the access cycle
  assign setup = psel & ~penable;
  assign take  = psel & penable & cur.pready;

  // Writes land at the completing edge; lane 0 holds all live bits
  assign wr_data = take & pwrite & pstrb[fbp_pkg::LANE0] &
                   (hit == fbp_pkg::FBP_HIT_DATA);
  assign wr_dir  = take & pwrite & pstrb[fbp_pkg::LANE0] &
                   (hit == fbp_pkg::FBP_HIT_DIR);

  ////////////////////////////////////////////////////////////////////////
  // Per-pin read view

  // Output pins show their latch, input pins the settled pin level
  for (genvar i = 0; i < fbp_pkg::PINS; i++) begin : g_pin
    assign port_view[i] = cur.dir[i] ? keep.latch[i]
                                     : sif.sync[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state of the reset-domain registers

  always_comb begin
    next_cur         = cur;
    next_cur.pready  = setup;
    next_cur.pslverr = setup & (hit == fbp_pkg::FBP_HIT_NONE);
    next_cur.prdata  = fbp_pkg::RD_IDLE;
    // Read data is captured at the setup edge, held for the access
    if (setup && !pwrite) begin
      case (hit)
        fbp_pkg::FBP_HIT_DATA: begin
          next_cur.prdata = {fbp_pkg::RD_PAD, port_view};
        end
        fbp_pkg::FBP_HIT_DIR: begin
          next_cur.prdata = {fbp_pkg::RD_PAD, cur.dir};
        end
        default: begin
          next_cur.prdata = fbp_pkg::RD_IDLE;
        end
      endcase
    end
    // Upper write bits fall away in the part-select
    if (wr_dir) begin
      next_cur.dir = pwdata[fbp_pkg::PINS-1:0];
    end
    // Driven value moves with the enable, so a latch loaded first
    // comes out clean when the buffer turns on
    next_cur.pin_out = next_cur.dir & next_keep.latch;
  end

  // Registers that reset brings to known values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.dir     <= fbp_pkg::DIR_RESET;
      cur.pin_out <= fbp_pkg::OUT_RESET;
      cur.prdata  <= fbp_pkg::RD_IDLE;
      cur.pready  <= 1'b0;
      cur.pslverr <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output latch

  // Written whatever the direction; input pins ignore it
  always_comb begin
    next_keep = keep;
    if (wr_data) begin
      next_keep.latch = pwdata[fbp_pkg::PINS-1:0];
    end
  end

  // No reset: the latch keeps its contents across a system reset
  always_ff @(posedge pclk) begin
    keep <= next_keep;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign prdata  = cur.prdata;
  assign pready  = cur.pready;
  assign pslverr = cur.pslverr;
  assign pin_out = cur.pin_out;
  assign pin_oe  = cur.dir;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Set once software has written the direction register
  logic dir_written;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_written <= 1'b0;
    end else if (wr_dir) begin
      dir_written <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  // All pins stay inputs from reset until a direction write
  a_dir_reset_clear: assert property (
    !dir_written |-> (pin_oe == fbp_pkg::DIR_RESET)
  ) else $error("pin enabled before any direction write");

  // A direction write lands on the enables one edge later
  a_dir_write_lands: assert property (
    wr_dir |=> (pin_oe == $past(pwdata[fbp_pkg::PINS-1:0]))
  ) else $error("direction write not seen on pin enables");

  // Direction read returns the bits last written
  a_dir_readback: assert property (
    setup && !pwrite && (hit == fbp_pkg::FBP_HIT_DIR)
    |=> pready && (prdata[fbp_pkg::PINS-1:0] == $past(pin_oe))
  ) else $error("direction read differs from stored bits");

  // Data read mixes latch and pin level per direction bit
  // Gated until the synchroniser holds levels sampled after reset
  a_data_read_mix: assert property (
    setup && !pwrite && (hit == fbp_pkg::FBP_HIT_DATA) && $past(presetn, 2)
    |=> (prdata[fbp_pkg::PINS-1:0] ==
         (($past(pin_oe) & $past(keep.latch)) |
          (~$past(pin_oe) & $past(pin_in, 3))))
  ) else $error("data read returns wrong source");

  // Input level reaches the read path after two edges
  // The second stage holds its reset value for the first two edges after release
  a_sync_two_stage: assert property (
    $past(presetn, 2) |-> (sif.sync == $past(pin_in, 2))
  ) else $error("synchroniser delay is not two cycles");

  // A latch write takes effect even on input pins
  a_latch_write: assert property (
    wr_data |=> (keep.latch == $past(pwdata[fbp_pkg::PINS-1:0]))
  ) else $error("latch write lost");

  // Latch keeps its value when not written
  a_latch_held: assert property (
    !wr_data |=> $stable(keep.latch)
  ) else $error("latch changed without a write");

  // Driven pin shows the latch once the enable is up
  a_pin_follows: assert property (
    wr_data ##1 (pin_oe == {fbp_pkg::PINS{1'b1}})
    |-> (pin_out == $past(pwdata[fbp_pkg::PINS-1:0]))
  ) else $error("driven pin does not show latch");

  // Unimplemented upper bits always read zero
  a_upper_zero: assert property (
    pready |-> (prdata[fbp_pkg::DATA_W-1:fbp_pkg::PINS] == fbp_pkg::RD_PAD)
  ) else $error("upper read bits not zero");

  // Five pins, each its own direction: undriven pins carry zero
  a_pin_per_bit: assert property (
    (pin_out & ~pin_oe) == fbp_pkg::OUT_RESET
  ) else $error("undriven pin carries a value");

  // Unmapped address answers one cycle later with an error
  a_unmapped_err: assert property (
    setup && (hit == fbp_pkg::FBP_HIT_NONE) |=> pready && pslverr
  ) else $error("unmapped access not flagged");

  // Ready is a one-cycle answer to a setup cycle
  a_ready_pulse: assert property (
    pready |-> $past(setup) ##1 !pready
  ) else $error("ready not a single-cycle answer");

  ////////////////////////////////////////////////////////////////////////
  // Bus response checks

  // Every setup cycle is answered in the very next cycle
  a_setup_answered: assert property (
    setup |=> pready
  ) else $error("setup cycle not answered");

  // Error only ever rides on a ready pulse
  a_err_with_ready: assert property (
    pslverr |-> pready
  ) else $error("error raised without ready");

  // Mapped registers never answer with an error
  a_mapped_no_err: assert property (
    setup && (hit != fbp_pkg::FBP_HIT_NONE) |=> !pslverr
  ) else $error("mapped access flagged as error");

  // Read data is zero outside the access cycle
  a_idle_read_zero: assert property (
    !pready |-> (prdata == fbp_pkg::RD_IDLE)
  ) else $error("read data outside access cycle");

  // A write returns no read data
  a_write_no_data: assert property (
    setup && pwrite |=> (prdata == fbp_pkg::RD_IDLE)
  ) else $error("write answered with read data");

  // Lane 0 strobe low drops the write on both registers
  a_strobe_drop: assert property (
    take && pwrite && !pstrb[fbp_pkg::LANE0] |=> $stable(pin_oe) && $stable(keep.latch)
  ) else $error("write landed with lane 0 strobe low");

  ////////////////////////////////////////////////////////////////////////
  // Pin and reset checks

  // Driven value is always the latch masked by the enables
  a_pin_out_mask: assert property (
    pin_out == (pin_oe & keep.latch)
  ) else $error("pin drive differs from masked latch");

  // Enables change only through a direction write
  a_dir_held: assert property (
    !wr_dir |=> $stable(pin_oe)
  ) else $error("direction bits changed without a write");

  // A pin turns into an output only after a direction write
  a_oe_rise_cause: assert property (
    (pin_oe & ~$past(pin_oe)) != fbp_pkg::DIR_RESET |-> $past(wr_dir)
  ) else $error("pin enabled without a direction write");

  // A driven bit rises only after a latch or direction write
  a_drive_rise_cause: assert property (
    (pin_out & ~$past(pin_out)) != fbp_pkg::OUT_RESET |-> $past(wr_dir || wr_data)
  ) else $error("pin drive rose without a write");

  // A direction write leaves the latch alone
  a_latch_no_dir: assert property (
    wr_dir |=> $stable(keep.latch)
  ) else $error("direction write disturbed the latch");

  // First edge after release: every pin still an input
  a_dir_after_reset: assert property (
    !$past(presetn) |-> (pin_oe == fbp_pkg::DIR_RESET)
  ) else $error("pin enabled right after reset");

  // First edge after release: synchroniser still at its reset value
  a_sync_after_reset: assert property (
    !$past(presetn) |-> (sif.sync == fbp_pkg::SYNC_RESET)
  ) else $error("synchroniser not cleared by reset");

endmodule

// *** src/fbp_pkg.sv ***
// Constants and types shared by the five-pin bidirectional port
package fbp_pkg;

  // Port geometry
  localparam int unsigned PINS   = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PAD_W  = DATA_W - PINS;

  // Register indices; each register sits on one aligned word
  localparam logic [ADDR_W-1:0] DATA_IDX  = 12'h002;
  localparam logic [ADDR_W-1:0] DIR_IDX   = 12'h006;
  localparam logic [ADDR_W-1:0] DATA_ADDR = DATA_IDX << 2;
  localparam logic [ADDR_W-1:0] DIR_ADDR  = DIR_IDX << 2;

  // Reset values and idle read value
  localparam logic [PINS-1:0]   DIR_RESET = 5'h00;
  localparam logic [PINS-1:0]   OUT_RESET = 5'h00;
  localparam logic [PINS-1:0]   SYNC_RESET = 5'h00;
  localparam logic [DATA_W-1:0] RD_IDLE   = 32'h0000_0000;
  localparam logic [PAD_W-1:0]  RD_PAD    = 27'h000_0000;

  // Byte lane that carries the implemented bits
  localparam int unsigned LANE0 = 0;

  // Address decode result
  typedef enum logic [1:0] {
    FBP_HIT_NONE = 2'b00,
    FBP_HIT_DATA = 2'b01,
    FBP_HIT_DIR  = 2'b10
  } fbp_hit_e;

  // State that a reset returns to a known value
  typedef struct packed {
    logic [PINS-1:0]   dir;
    logic [PINS-1:0]   pin_out;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } fbp_regs_s;

  // State that keeps its contents through reset
  typedef struct packed {
    logic [PINS-1:0] latch;
  } fbp_keep_s;

  // Two synchroniser stages
  typedef struct packed {
    logic [PINS-1:0] stage1;
    logic [PINS-1:0] stage2;
  } fbp_sync_s;

endpackage

// *** src/fbp_sync_if.sv ***
// Interface carrying raw and synchronised pin levels
`timescale 1ns/1ns
interface fbp_sync_if;
  logic [fbp_pkg::PINS-1:0] raw;
  logic [fbp_pkg::PINS-1:0] sync;

  modport port_side (output raw, input sync);
  modport sync_side (input raw, output sync);
endinterface

// *** src/fbp_pin_sync.sv ***
// Two-stage synchroniser for the port input pins
`timescale 1ns/1ns
module fbp_pin_sync (
  input wire logic         pclk,
  input wire logic         presetn,
  fbp_sync_if.sync_side    sif
);

  fbp_pkg::fbp_sync_s st;
  fbp_pkg::fbp_sync_s next_st;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; nothing else looks at it
  always_comb begin
    next_st        = st;
    next_st.stage1 = sif.raw;
    next_st.stage2 = st.stage1;
  end

  // Registers of both stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= {fbp_pkg::SYNC_RESET, fbp_pkg::SYNC_RESET};
    end else begin
      st <= next_st;
    end
  end

  // Settled level for the read path
  assign sif.sync = st.stage2;

endmodule

// *** testbench/fbp_pin_model.sv ***
// Off-chip circuitry seen by the five port pins
`timescale 1ns/1ns
module fbp_pin_model (
  input  wire logic                     pclk,
  input  wire logic [fbp_pkg::PINS-1:0] pin_out,
  input  wire logic [fbp_pkg::PINS-1:0] pin_oe,
  input  wire logic [fbp_pkg::PINS-1:0] ext_val,
  input  wire logic [fbp_pkg::PINS-1:0] ext_en,
  output logic      [fbp_pkg::PINS-1:0] pin_in
);
  logic [fbp_pkg::PINS-1:0] flt = '0;

  // An undriven pin has no pull, so it wanders instead of holding its last level
  always_ff @(posedge pclk) begin
    flt <= ~flt;
  end

  // Port drive wins, then the outside world, else the floating pattern
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & flt);
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the five-pin port
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, st;
  logic [4:0]  pin_in, pin_out, pin_oe, ext_val, ext_en;
  int          errors, total_checks, cycles;
  localparam logic [11:0] DA = fbp_pkg::DATA_ADDR;
  localparam logic [11:0] DR = fbp_pkg::DIR_ADDR;

  fbp_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  fbp_pin_model i_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs well under 1000 cycles
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // APB master: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_inputs();
    apb(0, DR, 0); chk("dir reset", 0, rd);
    chk("oe reset", 0, {27'h0, pin_oe});
    apb(1, DA, 32'h1f); repeat (3) @(posedge pclk);
    apb(0, DA, 0); chk("input read", 32'h0a, rd);
  endtask

  task automatic t_outputs();
    apb(1, DR, 32'hffff_ffe5); @(posedge pclk);
    chk("oe", 32'h05, {27'h0, pin_oe});
    chk("pin drive", 32'h05, {27'h0, pin_out});
    apb(0, DR, 0); chk("dir read", 32'h05, rd);
    apb(0, DA, 0); chk("mixed read", 32'h0f, rd);
    apb(1, DA, 32'hffff_fff4); @(posedge pclk);
    chk("pin after latch", 32'h04, {27'h0, pin_out});
    apb(0, DA, 0); chk("latch read", 32'h0e, rd);
    st = 4'he; apb(1, DR, 0); st = 4'hf; // Lane 0 strobe off
    apb(0, DR, 0); chk("strobe drop", 32'h05, rd);
  endtask

  task automatic t_unmapped();
    apb(1, 12'h00c, 32'h1f); chk("err write", 1, {31'h0, er});
    apb(0, 12'h00c, 0); chk("err read", 0, rd);
    apb(0, DR, 0); chk("dir kept", 32'h05, rd);
    chk("ok no err", 0, {31'h0, er});
  endtask

  task automatic t_sync();
    apb(1, DR, 0); repeat (4) @(posedge pclk);
    ext_val <= 5'h15; // New level lands just before the read
    apb(0, DA, 0); chk("sync old", 32'h0a, rd);
    repeat (3) @(posedge pclk);
    apb(0, DA, 0); chk("sync new", 32'h15, rd);
  endtask

  task automatic t_reset_keep();
    do_reset();
    apb(0, DR, 0); chk("dir rereset", 0, rd);
    apb(1, DR, 32'h1f); apb(0, DA, 0); chk("latch kept", 32'h14, rd);
    apb(1, DA, 32'h0b); @(posedge pclk);
    chk("pin follows", 32'h0b, {27'h0, pin_out});
    apb(0, DA, 0); chk("latch out", 32'h0b, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; st = 4'hf; ext_val = 5'h0a; ext_en = 5'h1f;
    errors = 0; total_checks = 0; cycles = 0;
    do_reset();
    t_inputs();
    t_outputs();
    t_unmapped();
    t_sync();
    t_reset_keep();
    close_out();
  end
endmodule
